// file: eic_ctrl.v
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eic_defines.vh"

module eic_ctrl #(
    parameter MCYCLE_CLKS = `EIC_MCYCLE_CLKS
) (
    // clock and reset
    input wire CORE_CLK,
    input wire NRST,
    // external request pins
    input wire EXT_REQUEST_PIN_TWO,
    input wire EXT_REQUEST_PIN_THREE,
    // core side: service acknowledge pulses
    input wire SERVICE_ACK_TWO,
    input wire SERVICE_ACK_THREE,
    // core side: forwarded requests
    output reg IRQ_TWO_HIGH,
    output reg IRQ_TWO_LOW,
    output reg IRQ_THREE_HIGH,
    output reg IRQ_THREE_LOW,
    // interrupt output
    output reg IRQ,
    // AXI4-Lite write address
    input wire [7:0] S_AXI_AWADDR,
    input wire S_AXI_AWVALID,
    output reg S_AXI_AWREADY,
    // AXI4-Lite write data
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    input wire S_AXI_WVALID,
    output reg S_AXI_WREADY,
    // AXI4-Lite write response
    output reg [1:0] S_AXI_BRESP,
    output reg S_AXI_BVALID,
    input wire S_AXI_BREADY,
    // AXI4-Lite read address
    input wire [7:0] S_AXI_ARADDR,
    input wire S_AXI_ARVALID,
    output reg S_AXI_ARREADY,
    // AXI4-Lite read data
    output reg [31:0] S_AXI_RDATA,
    output reg [1:0] S_AXI_RRESP,
    output reg S_AXI_RVALID,
    input wire S_AXI_RREADY
);

    reg [7:0] control;
    reg [`EIC_EVT_W-1:0] evt_status;
    reg [`EIC_EVT_W-1:0] evt_mask;
    reg [1:0] pin_meta;
    reg [1:0] pin_sync;
    reg [1:0] pin_sample;
    reg [1:0] pin_prev;
    reg [7:0] mcycle_cnt;
    reg mcycle_tick;

    // bus-side state
    reg [7:0] aw_addr;
    reg aw_held;
    reg [31:0] w_data;
    reg w_byte0;
    reg w_held;

    // decoded fields and next values
    wire [1:0] pin_async;
    wire [1:0] ack;
    wire [1:0] en;
    wire [1:0] trig_edge;
    wire [1:0] pri;
    wire [1:0] flag;
    wire [1:0] edge_seen;
    wire [1:0] req;
    wire wr_go;
    wire wr_ctrl;
    wire wr_status;
    wire wr_mask;
    wire [7:0] wd;
    wire wr_map;
    wire mcycle_end;
    wire [1:0] wd_flag;
    wire [1:0] next_flag;

    // next values of registered state
    reg [7:0] next_mcycle_cnt;
    reg [1:0] next_status;
    reg next_irq;
    reg [3:0] next_fwd;
    reg [1:0] next_bresp;
    reg [31:0] next_rdata;
    reg [1:0] next_rresp;

    assign pin_async = {EXT_REQUEST_PIN_THREE, EXT_REQUEST_PIN_TWO};
    assign ack = {SERVICE_ACK_THREE, SERVICE_ACK_TWO};
    assign en = {control[`EIC_BIT_EN3], control[`EIC_BIT_EN2]};
    assign trig_edge = {control[`EIC_BIT_TRIG3], control[`EIC_BIT_TRIG2]};
    assign pri = {control[`EIC_BIT_PRI3], control[`EIC_BIT_PRI2]};
    assign flag = {control[`EIC_BIT_FLAG3], control[`EIC_BIT_FLAG2]};

    // two-stage synchroniser; only pin_sync is read by logic
    // pins idle high, so resetting high keeps a false edge out after reset
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            pin_meta <= `EIC_PIN_IDLE;
            pin_sync <= `EIC_PIN_IDLE;
        end else begin
            pin_meta <= pin_async;
            pin_sync <= pin_meta;
        end
    end

    // machine cycle timebase; the tick is registered so samples land on one edge
    assign mcycle_end = (mcycle_cnt == MCYCLE_CLKS - 1);

    always @* begin
        if (mcycle_end)
            next_mcycle_cnt = 8'h00;
        else
            next_mcycle_cnt = mcycle_cnt + 8'h01;
    end

    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            mcycle_cnt <= 8'h00;
            mcycle_tick <= 1'b0;
        end else begin
            mcycle_cnt <= next_mcycle_cnt;
            mcycle_tick <= mcycle_end;
        end
    end

    // once-per-machine-cycle samples; pins held a full cycle are never missed
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            pin_sample <= `EIC_PIN_IDLE;
            pin_prev <= `EIC_PIN_IDLE;
        end else if (mcycle_tick) begin
            pin_sample <= pin_sync;
            pin_prev <= pin_sample;
        end
    end

    // write path decode
    assign wr_go = aw_held && w_held && !S_AXI_BVALID;
    assign wr_ctrl = wr_go && w_byte0 && (aw_addr == `EIC_ADDR_CONTROL);
    assign wr_status = wr_go && w_byte0 && (aw_addr == `EIC_ADDR_STATUS);
    assign wr_mask = wr_go && w_byte0 && (aw_addr == `EIC_ADDR_MASK);
    assign wr_map = (aw_addr == `EIC_ADDR_CONTROL) || (aw_addr == `EIC_ADDR_STATUS) ||
        (aw_addr == `EIC_ADDR_MASK) || (aw_addr == `EIC_ADDR_MCYCLE);
    // only byte lane 0 carries register bits; other lanes are dropped
    assign wd = w_data[7:0];
    assign wd_flag = {wd[`EIC_BIT_FLAG3], wd[`EIC_BIT_FLAG2]};

    // per-source flag and request logic
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_src
            // falling edge: previous sample high, current low
            assign edge_seen[i] = mcycle_tick && pin_prev[i] && !pin_sample[i];
            // edge mode uses sticky flag, level mode the live low sample
            assign req[i] = en[i] && (trig_edge[i] ? flag[i] : !pin_sample[i]);

            // flag priority: edge set, then service clear, then software write
            reg next_flag_bit;
            always @* begin
                next_flag_bit = flag[i];
                if (wr_ctrl)
                    next_flag_bit = wd_flag[i];
                if (trig_edge[i] && ack[i])
                    next_flag_bit = 1'b0;
                if (trig_edge[i] && edge_seen[i])
                    next_flag_bit = 1'b1;
            end
            assign next_flag[i] = next_flag_bit;
        end
    endgenerate

    // control register: software bits plus flags that software writes and edge mode also sets and clears
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            control <= `EIC_RST_CONTROL;
        end else begin
            if (wr_ctrl) begin
                control[`EIC_BIT_PRI3] <= wd[`EIC_BIT_PRI3];
                control[`EIC_BIT_EN3] <= wd[`EIC_BIT_EN3];
                control[`EIC_BIT_TRIG3] <= wd[`EIC_BIT_TRIG3];
                control[`EIC_BIT_PRI2] <= wd[`EIC_BIT_PRI2];
                control[`EIC_BIT_EN2] <= wd[`EIC_BIT_EN2];
                control[`EIC_BIT_TRIG2] <= wd[`EIC_BIT_TRIG2];
            end
            // flags follow their per-source next value every cycle
            control[`EIC_BIT_FLAG3] <= next_flag[1];
            control[`EIC_BIT_FLAG2] <= next_flag[0];
        end
    end

    // forwarded requests sorted onto two priority levels
    always @* begin
        next_fwd[0] = req[0] && pri[0];
        next_fwd[1] = req[0] && !pri[0];
        next_fwd[2] = req[1] && pri[1];
        next_fwd[3] = req[1] && !pri[1];
    end

    // registered so every request output leaves a flip-flop
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            IRQ_TWO_HIGH <= 1'b0;
            IRQ_TWO_LOW <= 1'b0;
            IRQ_THREE_HIGH <= 1'b0;
            IRQ_THREE_LOW <= 1'b0;
        end else begin
            IRQ_TWO_HIGH <= next_fwd[0];
            IRQ_TWO_LOW <= next_fwd[1];
            IRQ_THREE_HIGH <= next_fwd[2];
            IRQ_THREE_LOW <= next_fwd[3];
        end
    end

    // sticky event status, write one to clear; new event beats the clear
    always @* begin
        next_status = evt_status;
        if (wr_status)
            next_status = evt_status & ~wd[1:0];
        next_status = next_status | edge_seen;
        // interrupt lags the status by one cycle
        next_irq = |(evt_status & evt_mask);
    end

    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            evt_status <= {`EIC_EVT_W{1'b0}};
            evt_mask <= `EIC_RST_MASK;
            IRQ <= 1'b0;
        end else begin
            evt_status <= next_status;
            if (wr_mask)
                evt_mask <= wd[1:0];
            IRQ <= next_irq;
        end
    end

    // refused offsets leave every register untouched
    always @* begin
        next_bresp = `EIC_RESP_SLVERR;
        if (wr_map)
            next_bresp = `EIC_RESP_OKAY;
    end

    // AXI write channel: address and data taken in either order
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            aw_addr <= 8'h00;
            aw_held <= 1'b0;
            w_data <= 32'h00000000;
            w_byte0 <= 1'b0;
            w_held <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `EIC_RESP_OKAY;
        end else begin
            // readies stay low while a response waits, so one write is open
            S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_held && !S_AXI_WREADY && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_addr <= S_AXI_AWADDR;
                aw_held <= 1'b1;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_data <= S_AXI_WDATA;
                w_byte0 <= S_AXI_WSTRB[0];
                w_held <= 1'b1;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= next_bresp;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // read mux; unmapped offsets answer with an error and zero data
    always @* begin
        next_rdata = 32'h00000000;
        next_rresp = `EIC_RESP_OKAY;
        case (S_AXI_ARADDR)
            `EIC_ADDR_CONTROL: begin
                next_rdata = {24'h000000, control};
            end
            `EIC_ADDR_STATUS: begin
                next_rdata = {30'h00000000, evt_status};
            end
            `EIC_ADDR_MASK: begin
                next_rdata = {30'h00000000, evt_mask};
            end
            `EIC_ADDR_MCYCLE: begin
                next_rdata = {30'h00000000, pin_sample};
            end
            default: begin
                next_rresp = `EIC_RESP_SLVERR;
            end
        endcase
    end

    // AXI read channel; reads have no side effects
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h00000000;
            S_AXI_RRESP <= `EIC_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_ARREADY <= 1'b0;
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA <= next_rdata;
                S_AXI_RRESP <= next_rresp;
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

endmodule // eic_ctrl

// file: eic_ctrl_chk.sv
`timescale 1ns/1ps
module eic_ctrl_chk (
    // clock and reset
    input wire CORE_CLK,
    input wire NRST,
    // requests
    input wire IRQ_TWO_HIGH,
    input wire IRQ_TWO_LOW,
    input wire IRQ_THREE_HIGH,
    input wire IRQ_THREE_LOW,
    // bus
    input wire S_AXI_AWREADY,
    input wire [1:0] S_AXI_BRESP,
    input wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire [31:0] S_AXI_RDATA,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    sequence s_ar_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    sequence s_r_wait;
        S_AXI_RVALID && !S_AXI_RREADY;
    endsequence
    chk_two_one_level: assert property (!(IRQ_TWO_HIGH && IRQ_TWO_LOW))
        else $error("two on both levels");
    chk_three_one_level: assert property (!(IRQ_THREE_HIGH && IRQ_THREE_LOW))
        else $error("three on both levels");
    chk_read_answer: assert property (s_ar_taken |=> S_AXI_RVALID)
        else $error("read not answered");
    chk_read_stands: assert property (s_r_wait |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read data dropped");
    chk_read_byte: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
        else $error("read upper bits set");
    chk_read_busy: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address taken while busy");
    chk_write_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("response dropped");
    chk_write_busy: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
        else $error("write taken while busy");
endmodule // eic_ctrl_chk
bind eic_ctrl eic_ctrl_chk u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .IRQ_TWO_HIGH(IRQ_TWO_HIGH), .IRQ_TWO_LOW(IRQ_TWO_LOW), .IRQ_THREE_HIGH(IRQ_THREE_HIGH),
    .IRQ_THREE_LOW(IRQ_THREE_LOW), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY));

// file: eic_ctrl_tb.sv
`timescale 1ns/1ps
`include "eic_defines.vh"
module eic_ctrl_tb;
    localparam MC = 4;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg [1:0] want_low = 2'h0;
    reg ack2 = 1'b0;
    reg ack3 = 1'b0;
    reg [7:0] awaddr = 8'h0;
    reg [7:0] araddr = 8'h0;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, irq, i2h, i2l, i3h, i3l;
    wire [1:0] bresp, rresp, pins;
    wire [31:0] rdata;
    integer bad_count = 0;
    integer checked = 0;
    eic_pin_model #(.MC(MC)) u_pins (.clk(clk), .want_low(want_low), .pin(pins));
    eic_ctrl #(.MCYCLE_CLKS(MC)) dut (.CORE_CLK(clk), .NRST(nrst),
        .EXT_REQUEST_PIN_TWO(pins[0]), .EXT_REQUEST_PIN_THREE(pins[1]),
        .SERVICE_ACK_TWO(ack2), .SERVICE_ACK_THREE(ack3), .IRQ_TWO_HIGH(i2h),
        .IRQ_TWO_LOW(i2l), .IRQ_THREE_HIGH(i3h), .IRQ_THREE_LOW(i3l), .IRQ(irq),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    initial begin
        forever #5 clk = ~clk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: got %h, want %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d, input [1:0] er);
        integer n;
        begin
            @(posedge clk);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                if (awready)
                    awvalid <= 1'b0;
                if (wready)
                    wvalid <= 1'b0;
                n = n + 1;
            end while (!bvalid && n < 60);
            if (!bvalid) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: write not answered", $time);
                awvalid <= 1'b0;
                wvalid <= 1'b0;
            end
            bready <= 1'b0;
            chk(bresp, er);
        end
    endtask
    task rd(input [7:0] a, input [1:0] er, input [31:0] ed);
        integer n;
        begin
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                if (arready)
                    arvalid <= 1'b0;
                n = n + 1;
            end while (!rvalid && n < 60);
            if (!rvalid) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: read not answered", $time);
                arvalid <= 1'b0;
            end
            rready <= 1'b0;
            chk(rresp, er);
            chk(rdata, ed);
        end
    endtask
    // fixed span covers sync, one machine cycle and the output register
    task settle;
        repeat (6 * MC) @(posedge clk);
    endtask
    task report_and_stop;
        begin
            $display("checked %0d, bad %0d", checked, bad_count);
            if (bad_count == 0 && checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        #300000;
        bad_count = bad_count + 1;
        report_and_stop;
    end
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(`EIC_ADDR_CONTROL, `EIC_RESP_OKAY, 32'h0);
        rd(8'hd0, `EIC_RESP_SLVERR, 32'h0);
        wr(`EIC_ADDR_CONTROL, 8'hdd, `EIC_RESP_OKAY);
        rd(`EIC_ADDR_CONTROL, `EIC_RESP_OKAY, 32'hdd);
        want_low <= 2'h1;
        settle;
        want_low <= 2'h0;
        settle;
        rd(`EIC_ADDR_CONTROL, `EIC_RESP_OKAY, 32'hdf);
        chk({i2h, i2l}, 2'h2);
        ack2 <= 1'b1;
        @(posedge clk);
        ack2 <= 1'b0;
        settle;
        rd(`EIC_ADDR_CONTROL, `EIC_RESP_OKAY, 32'hdd);
        chk(i2h, 1'b0);
        wr(`EIC_ADDR_CONTROL, 8'h40, `EIC_RESP_OKAY);
        // source three keeps its pin low until serviced and beyond
        want_low <= 2'h2;
        settle;
        chk({i3h, i3l}, 2'h1);
        rd(`EIC_ADDR_CONTROL, `EIC_RESP_OKAY, 32'h40);
        ack3 <= 1'b1;
        @(posedge clk);
        ack3 <= 1'b0;
        settle;
        chk(i3l, 1'b1);
        wr(`EIC_ADDR_CONTROL, 8'h00, `EIC_RESP_OKAY);
        settle;
        chk(i3l, 1'b0);
        want_low <= 2'h0;
        rd(`EIC_ADDR_STATUS, `EIC_RESP_OKAY, 32'h3);
        chk(irq, 1'b0);
        wr(`EIC_ADDR_MASK, 8'h02, `EIC_RESP_OKAY);
        settle;
        chk(irq, 1'b1);
        wr(`EIC_ADDR_STATUS, 8'h02, `EIC_RESP_OKAY);
        settle;
        chk(irq, 1'b0);
        rd(`EIC_ADDR_STATUS, `EIC_RESP_OKAY, 32'h1);
        rd(`EIC_ADDR_MASK, `EIC_RESP_OKAY, 32'h2);
        // edge mode on three and level mode on two together
        wr(`EIC_ADDR_CONTROL, 8'h54, `EIC_RESP_OKAY);
        want_low <= 2'h3;
        settle;
        rd(`EIC_ADDR_CONTROL, `EIC_RESP_OKAY, 32'h74);
        chk({i3h, i3l, i2h, i2l}, 4'h5);
        want_low <= 2'h0;
        ack3 <= 1'b1;
        @(posedge clk);
        ack3 <= 1'b0;
        settle;
        rd(`EIC_ADDR_CONTROL, `EIC_RESP_OKAY, 32'h54);
        chk({i3l, i2l}, 2'h0);
        // reset in mid-run brings the control register back
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(`EIC_ADDR_CONTROL, `EIC_RESP_OKAY, 32'h0);
        report_and_stop;
    end
endmodule // eic_ctrl_tb

// file: eic_defines.vh
`ifndef EIC_DEFINES_VH
`define EIC_DEFINES_VH

// register byte addresses
`define EIC_ADDR_CONTROL 8'hc0
`define EIC_ADDR_STATUS 8'hc4
`define EIC_ADDR_MASK 8'hc8
`define EIC_ADDR_MCYCLE 8'hcc

// control register bit positions
`define EIC_BIT_PRI3 7
`define EIC_BIT_EN3 6
`define EIC_BIT_FLAG3 5
`define EIC_BIT_TRIG3 4
`define EIC_BIT_PRI2 3
`define EIC_BIT_EN2 2
`define EIC_BIT_FLAG2 1
`define EIC_BIT_TRIG2 0

// reset values
`define EIC_RST_CONTROL 8'h00
`define EIC_RST_MASK 2'h0
`define EIC_PIN_IDLE 2'h3

// status / mask layout: bit 0 source two, bit 1 source three
`define EIC_EVT_W 2

// machine cycle = 12 core clocks
`define EIC_MCYCLE_CLKS 12

// AXI responses
`define EIC_RESP_OKAY 2'h0
`define EIC_RESP_SLVERR 2'h2

`endif

// file: eic_pin_model.sv
`timescale 1ns/1ps
module eic_pin_model #(
    parameter MC = 4
) (
    // clock
    input wire clk,
    // wanted levels, bit 0 source two
    input wire [1:0] want_low,
    // request pins
    output reg [1:0] pin
);
    integer hold0 = 0;
    integer hold1 = 0;
    initial pin = 2'h3;
    // a level is kept two machine cycles so no change slips between samples
    always @(posedge clk) begin
        if (hold0 > 0)
            hold0 <= hold0 - 1;
        else if (pin[0] == want_low[0]) begin
            pin[0] <= !want_low[0];
            hold0 <= 2 * MC + 2;
        end
        if (hold1 > 0)
            hold1 <= hold1 - 1;
        else if (pin[1] == want_low[1]) begin
            pin[1] <= !want_low[1];
            hold1 <= 2 * MC + 2;
        end
    end
endmodule // eic_pin_model
